// >>> hw/sfc_defs.svh
// Named constants for the serial flash erase and program command block.
// Assumes a 20 MHz system clock and a host that drives SPI mode 0 or 3.
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

`define SFC_CLK_MHZ 20
`define SFC_OPC_CHIP_ERASE_A 8'h60
`define SFC_OPC_CHIP_ERASE_B 8'hC7
`define SFC_OPC_PAGE_PROG 8'h02
`define SFC_OPC_WRITE_EN 8'h06
`define SFC_OPC_WRITE_DIS 8'h04
`define SFC_OPC_SUSPEND 8'h75
`define SFC_ADDR_BYTES 2'h3
`define SFC_BIT_LAST 3'h7
`define SFC_CHIP_ERASE_US 100000
`define SFC_PAGE_PROG_US 1000
`define SFC_BYTE_PROG_US 100
`define SFC_PAGE_BYTES 256

`endif

// >>> hw/sfc_pkg.sv
// Types shared by the serial flash command block.
// Assumes nothing beyond a SystemVerilog elaborator.
package sfc_pkg;
   typedef enum logic [3:0] {
      SFC_PH_OPC = 4'h1,
      SFC_PH_ADDR = 4'h2,
      SFC_PH_DATA = 4'h4,
      SFC_PH_SKIP = 4'h8
   } sfc_phase_t;
   typedef enum logic [2:0] {
      SFC_OP_IDLE = 3'h1,
      SFC_OP_ERASE = 3'h2,
      SFC_OP_PROG = 3'h4
   } sfc_op_t;
   typedef enum logic [4:0] {
      SFC_CMD_NONE = 5'h01,
      SFC_CMD_ERASE = 5'h02,
      SFC_CMD_PROG = 5'h04,
      SFC_CMD_WREN = 5'h08,
      SFC_CMD_WRDI = 5'h10
   } sfc_cmd_t;
endpackage : sfc_pkg

// >>> hw/sfc_page_buf.sv
// Page buffer memory: one write port, one read port with registered data.
// Assumes clk_en freezes it with the rest of the block.
module sfc_page_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
) (
   input wire logic clk_sys,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // No reset: contents only matter where the written mask says so
   always_ff @(posedge clk_sys) begin
      if (clk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule : sfc_page_buf

// >>> hw/sfc_flash_ctl.sv
// Chip erase and byte/page program command handling of a serial flash.
// Assumes SPI pins arrive asynchronously and the array sits outside on clk_sys.
`include "sfc_defs.svh"

module sfc_flash_ctl #(
   parameter int unsigned CHIP_ERASE_US = `SFC_CHIP_ERASE_US,
   parameter int unsigned PAGE_PROG_US = `SFC_PAGE_PROG_US,
   parameter int unsigned BYTE_PROG_US = `SFC_BYTE_PROG_US,
   parameter int PAGE_BYTES = `SFC_PAGE_BYTES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic [2:0] block_protect_field,
   input wire logic lock_scheme_select,
   input wire logic block_lock_any,
   input wire logic target_protected,
   input wire logic erase_fail,
   input wire logic clear_error_flags,
   output logic write_enable_latch,
   output logic operation_in_progress_flag,
   output logic erase_error_flag,
   output logic program_error_flag,
   output logic [23:0] target_addr,
   output logic array_erase_start,
   output logic array_wr_en,
   output logic [23:0] array_wr_addr,
   output logic [7:0] array_wr_data,
   output logic suspend_req,
   output sfc_pkg::sfc_op_t op_state
);
   import sfc_pkg::*;

   localparam int PTR_W = $clog2(PAGE_BYTES);
   // One less: the exit cycle still reads busy, so busy never outlasts the time
   localparam logic [31:0] ERASE_CYC = 32'(CHIP_ERASE_US * `SFC_CLK_MHZ - 1);
   localparam logic [31:0] PAGE_CYC = 32'(PAGE_PROG_US * `SFC_CLK_MHZ - 1);
   localparam logic [31:0] BYTE_CYC = 32'(BYTE_PROG_US * `SFC_CLK_MHZ - 1);
   localparam logic [PTR_W:0] WALK_END = (PTR_W+1)'(PAGE_BYTES);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(PAGE_BYTES - 1);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge finding
   logic [2:0] cs_sync;
   logic [2:0] sck_sync;
   logic [1:0] si_sync;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cs_sync <= 3'h7;
         sck_sync <= 3'h0;
         si_sync <= 2'h0;
      end else if (clk_en) begin
         cs_sync <= {cs_sync[1:0], cs_n_pin};
         sck_sync <= {sck_sync[1:0], sck_pin};
         si_sync <= {si_sync[0], si_pin};
      end
   end

   // Stage 0 feeds only stage 1; edges come from stages 1 and 2
   wire cs_fall = !cs_sync[1] && cs_sync[2];
   wire cs_rise = cs_sync[1] && !cs_sync[2];
   wire sck_rise = sck_sync[1] && !sck_sync[2] && !cs_sync[1];
   wire si_bit = si_sync[1];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Serial shifting
   sfc_phase_t phase;
   sfc_cmd_t cmd;
   logic frame_active;
   logic [2:0] bit_cnt;
   logic [6:0] shift;
   logic [1:0] addr_cnt;
   logic [15:0] page_addr;
   logic [PTR_W-1:0] start_low;
   logic [PTR_W-1:0] ptr;
   logic [1:0] data_cnt;
   logic [PAGE_BYTES-1:0] byte_written;
   logic [31:0] op_timer;
   logic [PTR_W:0] walk_idx;
   logic walk_vld_d;
   logic [PTR_W-1:0] walk_idx_d;
   logic [7:0] buf_rd_data;

   wire byte_done = sck_rise && bit_cnt == `SFC_BIT_LAST;
   wire [7:0] rx_byte = {shift, si_bit};
   wire busy = op_state != SFC_OP_IDLE;
   wire opc_done = byte_done && phase == SFC_PH_OPC;
   wire addr_done = byte_done && phase == SFC_PH_ADDR;
   wire data_done = byte_done && phase == SFC_PH_DATA;
   wire frame_end = cs_rise && frame_active;
   wire whole_bytes = bit_cnt == 3'h0;

   // Either chip erase opcode decodes alike
   wire is_erase_opc = rx_byte == `SFC_OPC_CHIP_ERASE_A || rx_byte == `SFC_OPC_CHIP_ERASE_B;
   wire is_prog_opc = rx_byte == `SFC_OPC_PAGE_PROG;
   wire is_suspend_opc = rx_byte == `SFC_OPC_SUSPEND;
   // Array commands need the latch and an idle array
   wire array_ok = write_enable_latch && !busy;
   wire sfc_cmd_t next_cmd = (is_erase_opc && array_ok) ? SFC_CMD_ERASE :
                             (is_prog_opc && array_ok) ? SFC_CMD_PROG :
                             (rx_byte == `SFC_OPC_WRITE_EN && !busy) ? SFC_CMD_WREN :
                             (rx_byte == `SFC_OPC_WRITE_DIS && !busy) ? SFC_CMD_WRDI :
                             SFC_CMD_NONE;
   wire sfc_phase_t next_phase_opc = (next_cmd == SFC_CMD_PROG) ? SFC_PH_ADDR : SFC_PH_SKIP;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase <= SFC_PH_OPC;
         cmd <= SFC_CMD_NONE;
         frame_active <= 1'b0;
         bit_cnt <= 3'h0;
         shift <= 7'h00;
      end else if (clk_en) begin
         if (cs_fall) begin
            phase <= SFC_PH_OPC;
            cmd <= SFC_CMD_NONE;
            frame_active <= 1'b1;
            bit_cnt <= 3'h0;
         end else if (cs_rise) begin
            frame_active <= 1'b0;
         end else if (sck_rise && frame_active) begin
            // Bits arrive MSB first
            shift <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (opc_done) begin
               cmd <= next_cmd;
               phase <= next_phase_opc;
            end else if (addr_done && addr_cnt == `SFC_ADDR_BYTES - 2'h1) begin
               phase <= SFC_PH_DATA;
            end
         end
      end
   end

   // Address then data; pointer wraps inside the page
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         addr_cnt <= 2'h0;
         page_addr <= 16'h0000;
         start_low <= '0;
         ptr <= '0;
         data_cnt <= 2'h0;
      end else if (clk_en) begin
         if (cs_fall) begin
            addr_cnt <= 2'h0;
            data_cnt <= 2'h0;
         end else if (frame_active && addr_done) begin
            // Address byte 0 carries bit 23
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == `SFC_ADDR_BYTES - 2'h1) begin
               start_low <= rx_byte[PTR_W-1:0];
               ptr <= rx_byte[PTR_W-1:0];
            end else begin
               page_addr <= {page_addr[7:0], rx_byte};
            end
         end else if (frame_active && data_done) begin
            ptr <= ptr + 1'b1;
            if (data_cnt != 2'h2) begin
               data_cnt <= data_cnt + 2'h1;
            end
         end
      end
   end

   assign target_addr = {page_addr, start_low};

   // Later bytes overwrite earlier ones at the same slot
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         byte_written <= '0;
      end else if (clk_en) begin
         if (opc_done && frame_active && next_cmd == SFC_CMD_PROG) begin
            byte_written <= '0;
         end else if (data_done && frame_active) begin
            byte_written[ptr] <= 1'b1;
         end
      end
   end

   sfc_page_buf #(
      .WIDTH(8),
      .DEPTH(PAGE_BYTES)
   ) u_page_buf (
      .clk_sys(clk_sys),
      .clk_en(clk_en),
      .wr_en(data_done && frame_active),
      .wr_addr(ptr),
      .wr_data(rx_byte),
      .rd_addr(walk_idx[PTR_W-1:0]),
      .rd_data(buf_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // End of frame decisions
   wire protect_any = block_protect_field != 3'h0 || (lock_scheme_select && block_lock_any);
   wire end_erase = frame_end && cmd == SFC_CMD_ERASE;
   wire end_prog = frame_end && cmd == SFC_CMD_PROG;
   wire prog_complete = whole_bytes && phase == SFC_PH_DATA && data_cnt != 2'h0;
   wire start_erase = end_erase && whole_bytes && !protect_any;
   wire start_prog = end_prog && prog_complete && !target_protected;
   wire wel_set = frame_end && cmd == SFC_CMD_WREN && whole_bytes;
   // Any end of an array command drops the latch: started, refused or aborted
   wire wel_clr = end_erase || end_prog || (frame_end && cmd == SFC_CMD_WRDI && whole_bytes);
   wire walk_run = op_state == SFC_OP_PROG && walk_idx != WALK_END;
   wire op_done = busy && op_timer == 32'h0 && !walk_run && !walk_vld_d;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         write_enable_latch <= 1'b0;
      end else if (clk_en) begin
         if (wel_clr) begin
            write_enable_latch <= 1'b0;
         end else if (wel_set) begin
            write_enable_latch <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Self-timed operation
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         op_state <= SFC_OP_IDLE;
         op_timer <= 32'h0;
      end else if (clk_en) begin
         case (op_state)
            SFC_OP_IDLE: begin
               if (start_erase) begin
                  op_state <= SFC_OP_ERASE;
                  op_timer <= ERASE_CYC;
               end else if (start_prog) begin
                  op_state <= SFC_OP_PROG;
                  op_timer <= (data_cnt == 2'h1) ? BYTE_CYC : PAGE_CYC;
               end
            end
            SFC_OP_ERASE, SFC_OP_PROG: begin
               if (op_done) begin
                  op_state <= SFC_OP_IDLE;
               end else if (op_timer != 32'h0) begin
                  op_timer <= op_timer - 32'h1;
               end
            end
            default: begin
               op_state <= SFC_OP_IDLE;
            end
         endcase
      end
   end

   assign operation_in_progress_flag = busy;

   // Walk the page once, writing only slots that were received
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         walk_idx <= '0;
         walk_vld_d <= 1'b0;
         walk_idx_d <= '0;
         array_wr_en <= 1'b0;
         array_wr_addr <= 24'h000000;
         array_wr_data <= 8'h00;
         array_erase_start <= 1'b0;
      end else if (clk_en) begin
         if (start_prog) begin
            walk_idx <= '0;
         end else if (walk_run) begin
            walk_idx <= walk_idx + 1'b1;
         end
         walk_vld_d <= walk_run;
         walk_idx_d <= walk_idx[PTR_W-1:0];
         array_wr_en <= walk_vld_d && byte_written[walk_idx_d];
         array_wr_addr <= {page_addr, walk_idx_d};
         array_wr_data <= buf_rd_data;
         array_erase_start <= start_erase;
      end
   end

   // Suspend is honoured only for a byte or page program
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         suspend_req <= 1'b0;
      end else if (clk_en) begin
         suspend_req <= opc_done && frame_active && is_suspend_opc &&
                        op_state == SFC_OP_PROG;
      end
   end

   // Set wins over a clear in the same cycle
   wire erase_err_event = op_state == SFC_OP_ERASE && erase_fail;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         erase_error_flag <= 1'b0;
         program_error_flag <= 1'b0;
      end else if (clk_en) begin
         if (erase_err_event) begin
            erase_error_flag <= 1'b1;
            program_error_flag <= 1'b1;
         end else if (clear_error_flags) begin
            erase_error_flag <= 1'b0;
            program_error_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   erase_needs_latch_a: assert property ($rose(op_state == SFC_OP_ERASE) |->
      $past(write_enable_latch)) else $error("erase started without latch");
   erase_clears_latch_a: assert property ($rose(op_state == SFC_OP_ERASE) |->
      !write_enable_latch && array_erase_start) else $error("latch still set at erase");
   protect_refuse_a: assert property (clk_en && !busy && end_erase && protect_any |=>
      op_state == SFC_OP_IDLE && !write_enable_latch) else $error("protected erase ran");
   partial_byte_a: assert property (clk_en && (end_erase || end_prog) && !whole_bytes |=>
      op_state == SFC_OP_IDLE && !write_enable_latch) else $error("partial byte not aborted");
   prog_incomplete_a: assert property (clk_en && end_prog && phase != SFC_PH_DATA |=>
      op_state == SFC_OP_IDLE && !array_wr_en) else $error("short program not aborted");
   prog_protect_a: assert property (clk_en && end_prog && target_protected |=>
      op_state == SFC_OP_IDLE && !write_enable_latch) else $error("protected program ran");
   busy_holds_a: assert property (clk_en && busy && op_timer > 32'h1 |=>
      operation_in_progress_flag) else $error("busy dropped early");
   no_restart_a: assert property (busy |=> !array_erase_start)
      else $error("new erase while busy");
   ptr_wrap_a: assert property (clk_en && frame_active && data_done && ptr == PTR_LAST |=>
      ptr == '0) else $error("pointer did not wrap");
   write_in_prog_a: assert property (array_wr_en |-> op_state == SFC_OP_PROG)
      else $error("array write outside program");
   error_sticky_a: assert property (clk_en && erase_err_event |=>
      erase_error_flag && program_error_flag) else $error("erase error not flagged");
   erase_opc_alike_a: assert property (clk_en && frame_active && !cs_fall && opc_done &&
      is_erase_opc && array_ok |=> cmd == SFC_CMD_ERASE) else $error("erase opcode lost");
   unsent_slot_a: assert property (clk_en && walk_vld_d && !byte_written[walk_idx_d] |=>
      !array_wr_en) else $error("unsent slot programmed");
   erase_no_suspend_a: assert property (clk_en && op_state == SFC_OP_ERASE |=>
      !suspend_req) else $error("suspend during chip erase");
endmodule : sfc_flash_ctl

// >>> test/sfc_spi_host.sv
// Host SPI controller model: drives mode 0 frames into the flash command block.
// Assumes one bench process calls frame() at a time, timed by clk_sys.
module sfc_spi_host (
   input wire logic clk_sys,
   output logic cs_n_pin,
   output logic sck_pin,
   output logic si_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n_pin = 1'b1;
      sck_pin = 1'b0;
      si_pin = 1'b1;
   end
   // Four clk_sys cycles per half period gives the 400 ns serial clock
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask : half
   // Whole bytes MSB first, then 'extra' loose bits; serial clock rests low between frames
   task automatic frame(input logic [7:0] bytes[$], input int extra);
      logic [7:0] b;
      @(posedge clk_sys);
      cs_n_pin <= 1'b0;
      half();
      for (int i = 0; i < bytes.size() + (extra > 0); i++) begin
         b = (i < bytes.size()) ? bytes[i] : 8'hA5;
         for (int k = 7; k >= 0; k--) begin
            if (i < bytes.size() || k > 7 - extra) begin
               si_pin <= b[k];
               half();
               sck_pin <= 1'b1;
               half();
               sck_pin <= 1'b0;
            end
         end
      end
      half();
      cs_n_pin <= 1'b1;
      // Released line shows the inverse of the last bit, never a stale value
      si_pin <= ~si_pin;
      // Deselect time before any following frame
      half();
   endtask : frame
endmodule : sfc_spi_host

// >>> test/test_serial_flash_chip_erase_page_program.sv
// Self-checking bench for the chip erase and byte/page program command block.
// Assumes sfc_spi_host as the SPI master and shortened self-timed durations.
module test_serial_flash_chip_erase_page_program;
   timeunit 1ns;
   timeprecision 1ps;
   import sfc_pkg::*;
   localparam int unsigned ER_US = 20;
   localparam int unsigned PG_US = 30;
   localparam int unsigned BY_US = 20;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cs_n_pin, sck_pin, si_pin;
   logic [2:0] block_protect_field = 3'h0;
   logic lock_scheme_select = 1'b0;
   logic block_lock_any = 1'b0;
   logic target_protected = 1'b0;
   logic erase_fail = 1'b0;
   logic clear_error_flags = 1'b0;
   logic write_enable_latch, operation_in_progress_flag, erase_error_flag;
   logic program_error_flag, array_erase_start, array_wr_en, suspend_req;
   logic [23:0] target_addr, array_wr_addr;
   logic [7:0] array_wr_data;
   sfc_op_t op_state;
   logic [7:0] seen [256];
   logic hit [256];
   logic [15:0] last_page;
   int err_total = 0;
   int num_checks = 0;
   int n_wr = 0;
   int n_er = 0;
   int n_su = 0;
   int busy_cyc = 0;
   always #25 clk_sys = ~clk_sys;
   sfc_spi_host host (.clk_sys(clk_sys), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
      .si_pin(si_pin));
   sfc_flash_ctl #(.CHIP_ERASE_US(ER_US), .PAGE_PROG_US(PG_US), .BYTE_PROG_US(BY_US),
      .PAGE_BYTES(256)) DUT (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1),
      .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
      .block_protect_field(block_protect_field), .lock_scheme_select(lock_scheme_select),
      .block_lock_any(block_lock_any), .target_protected(target_protected),
      .erase_fail(erase_fail), .clear_error_flags(clear_error_flags),
      .write_enable_latch(write_enable_latch),
      .operation_in_progress_flag(operation_in_progress_flag),
      .erase_error_flag(erase_error_flag), .program_error_flag(program_error_flag),
      .target_addr(target_addr), .array_erase_start(array_erase_start),
      .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
      .array_wr_data(array_wr_data), .suspend_req(suspend_req), .op_state(op_state));
   ////////////////////////////////////////////////////////////////////////////////
   // Array side: records every programmed byte and every start pulse
   always @(posedge clk_sys) begin
      if (array_wr_en === 1'b1) begin
         seen[array_wr_addr[7:0]] <= array_wr_data;
         hit[array_wr_addr[7:0]] <= 1'b1;
         last_page <= array_wr_addr[23:8];
         n_wr++;
      end
      if (array_erase_start === 1'b1) n_er++;
      if (suspend_req === 1'b1) n_su++;
      if (operation_in_progress_flag === 1'b1) busy_cyc++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // Polls busy instead of waiting the worst-case time; busy_cyc counts only cycles with busy set
   task automatic wait_idle();
      int n;
      n = 0;
      while (operation_in_progress_flag !== 1'b0) begin
         cyc(1);
         n++;
         if (n > 20000) begin
            err_total++;
            results();
         end
      end
   endtask : wait_idle
   task automatic wren();
      host.frame('{8'h06}, 0);
      cyc(8);
      check(write_enable_latch, 1'b1);
   endtask : wren
   // Command frame that must be refused: nothing starts and the latch ends cleared
   task automatic refused(input logic [7:0] q[$], input int extra);
      n_wr = 0;
      n_er = 0;
      host.frame(q, extra);
      cyc(10);
      check(operation_in_progress_flag, 1'b0);
      check(write_enable_latch, 1'b0);
      check(n_wr + n_er, 0);
   endtask : refused
   task automatic t_refusals();
      refused('{8'h60}, 0);
      block_protect_field <= 3'h4;
      wren();
      refused('{8'hC7}, 0);
      block_protect_field <= 3'h0;
      lock_scheme_select <= 1'b1;
      block_lock_any <= 1'b1;
      wren();
      refused('{8'h60}, 0);
      lock_scheme_select <= 1'b0;
      block_lock_any <= 1'b0;
      wren();
      refused('{8'h60}, 4);
      wren();
      refused('{8'h02, 8'h00, 8'h12}, 0);
      wren();
      refused('{8'h02, 8'h00, 8'h12, 8'h00, 8'hAA}, 3);
      target_protected <= 1'b1;
      wren();
      refused('{8'h02, 8'h00, 8'h00, 8'h10, 8'h55}, 0);
      target_protected <= 1'b0;
   endtask : t_refusals
   task automatic t_erase(input logic [7:0] opc);
      wren();
      n_er = 0;
      n_su = 0;
      busy_cyc = 0;
      host.frame('{opc}, 0);
      cyc(10);
      check(op_state, SFC_OP_ERASE);
      check(operation_in_progress_flag, 1'b1);
      check(write_enable_latch, 1'b0);
      check(n_er, 1);
      erase_fail <= 1'b1;
      cyc(1);
      erase_fail <= 1'b0;
      host.frame('{8'h75}, 0);
      host.frame('{8'h06}, 0);
      cyc(8);
      check(n_su, 0);
      check(write_enable_latch, 1'b0);
      check({erase_error_flag, program_error_flag}, 2'h3);
      wait_idle();
      check(busy_cyc > ER_US * 20 - 40 && busy_cyc <= ER_US * 20, 1'b1);
      clear_error_flags <= 1'b1;
      cyc(1);
      clear_error_flags <= 1'b0;
      cyc(2);
      check({erase_error_flag, program_error_flag}, 2'h0);
   endtask : t_erase
   // Bytes from slot FE wrap to 00, and only received slots are programmed
   task automatic t_wrap();
      for (int i = 0; i < 256; i++) hit[i] = 1'b0;
      wren();
      n_wr = 0;
      n_su = 0;
      busy_cyc = 0;
      host.frame('{8'h02, 8'h00, 8'h12, 8'hFE, 8'hA1, 8'hB2, 8'hC3}, 0);
      cyc(8);
      check(op_state, SFC_OP_PROG);
      check(operation_in_progress_flag, 1'b1);
      check(target_addr, 24'h0012FE);
      host.frame('{8'h02, 8'h00, 8'h00, 8'h00, 8'h11}, 0);
      cyc(8);
      check(write_enable_latch, 1'b0);
      host.frame('{8'h75}, 0);
      cyc(8);
      check(n_su, 1);
      wait_idle();
      check(busy_cyc > PG_US * 20 - 40 && busy_cyc <= PG_US * 20, 1'b1);
      check(n_wr, 3);
      check({seen[8'hFE], seen[8'hFF], seen[8'h00]}, 24'hA1B2C3);
      check(last_page, 16'h0012);
      check(hit[8'h01], 1'b0);
   endtask : t_wrap
   task automatic t_single();
      wren();
      n_wr = 0;
      busy_cyc = 0;
      host.frame('{8'h02, 8'h00, 8'h40, 8'h07, 8'h3C}, 0);
      cyc(8);
      wait_idle();
      check(busy_cyc > BY_US * 20 - 40 && busy_cyc <= BY_US * 20, 1'b1);
      check(n_wr, 1);
      check(seen[8'h07], 8'h3C);
   endtask : t_single
   task automatic t_overflow();
      logic [7:0] q[$];
      q = '{8'h02, 8'h00, 8'h34, 8'h00};
      for (int i = 0; i < 258; i++) q.push_back(i < 256 ? i[7:0] : 8'hE0 + i[7:0]);
      wren();
      n_wr = 0;
      host.frame(q, 0);
      cyc(8);
      wait_idle();
      check(n_wr, 256);
      check({seen[8'h00], seen[8'h01], seen[8'h02], seen[8'hFF]}, 32'hE0E102FF);
      check(last_page, 16'h0034);
   endtask : t_overflow
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(6);
      resetn <= 1'b1;
      cyc(4);
      check({write_enable_latch, operation_in_progress_flag}, 2'h0);
      t_refusals();
      t_erase(8'h60);
      t_erase(8'hC7);
      t_wrap();
      t_single();
      t_overflow();
      results();
   end
endmodule : test_serial_flash_chip_erase_page_program
